/* design/oic_pkg.sv */
package oic_pkg;
   // register byte offsets
   localparam logic [7:0] A_OUT_EN = 8'h00;
   localparam logic [7:0] A_PROT_OFF = 8'h04;
   localparam logic [7:0] A_DRIVE = 8'h08;
   localparam logic [7:0] A_INSEL = 8'h0C;
   localparam logic [7:0] A_CONFIG = 8'h10;
   localparam logic [7:0] A_PULSE = 8'h14;
   localparam logic [7:0] A_LATCH = 8'h18;
   localparam logic [7:0] A_STATE = 8'h1C;
   localparam logic [7:0] A_FAULT = 8'h20;
   // latch bit positions
   localparam int L_OVV = 0;
   localparam int L_SELFTEST = 1;
   localparam int L_SELFCHK = 2;
   localparam int L_PINRST = 3;
   localparam int L_WDG = 4;
   localparam int NLATCH = 5;
   // channel groups
   localparam logic [7:0] MASK_MAIN = 8'h3F;
   localparam logic [7:0] MASK_CH6 = 8'h20;
   localparam logic [7:0] MASK_ALL = 8'hFF;
   // reset values
   localparam logic [7:0] RST_OUT_EN = 8'h00;
   localparam logic [11:0] RST_PINS = 12'hFFE;
   localparam logic [2:0] RST_SPI_PINS = 3'h2;
   // pulse timing
   localparam int CLK_HZ = 20_000_000;
   localparam int PULSE_ON_US = 80;
   localparam int PULSE_OFF_US = 100;
   localparam int PULSE_ON_CYC = (PULSE_ON_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int PULSE_OFF_CYC = (PULSE_OFF_US * CLK_HZ + 999_999) / 1_000_000;
   // integrity query frames
   localparam logic [31:0] CMD_LOW = 32'hBAAA_AAAA;
   localparam logic [31:0] CMD_HIGH = 32'hCAAA_AAAB;
   localparam logic [3:0] HDR_LOW = 4'hB;
   localparam logic [3:0] HDR_HIGH = 4'hC;
   localparam logic [6:0] HDR_MID = 7'h55;
   typedef enum logic [1:0] {
      DRV_OFF = 2'b00,
      DRV_ON = 2'b01,
      DRV_TRI = 2'b10
   } oic_drv_t;
endpackage

/* design/oic_frame_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface oic_frame_if;
   logic [31:0] rx_word;
   logic [31:0] tx_word;
   logic frame_done;
   modport link (output rx_word, output frame_done, input tx_word);
   modport core (input rx_word, input frame_done, output tx_word);
endinterface
`default_nettype wire

/* design/oic_spi_frame.sv */
`timescale 1ns/1ps
`default_nettype none
module oic_spi_frame
   import oic_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   oic_frame_if.link fr
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic prev_sck;
      logic prev_cs;
      logic [31:0] sh_in;
      logic [31:0] sh_out;
      logic miso;
      logic done;
      logic [31:0] rx;
   } oic_spi_state_t;
   oic_spi_state_t q;
   oic_spi_state_t next_q;
   logic sck;
   logic cs_n;
   logic mosi;
   always_comb
   begin
      next_q = q;
      next_q.s1 = {spi_mosi, spi_cs_n, spi_sck};
      next_q.s2 = q.s1;
      sck = q.s2[0];
      cs_n = q.s2[1];
      mosi = q.s2[2];
      next_q.prev_sck = sck;
      next_q.prev_cs = cs_n;
      next_q.done = 1'b0;
      if (q.prev_cs && !cs_n)
      begin
         // reply of the previous frame goes out now
         next_q.sh_out = fr.tx_word;
         next_q.miso = fr.tx_word[31];
      end
      else if (!cs_n && sck && !q.prev_sck)
      begin
         next_q.sh_in = {q.sh_in[30:0], mosi};
      end
      else if (!cs_n && !sck && q.prev_sck)
      begin
         next_q.sh_out = {q.sh_out[30:0], 1'b0};
         next_q.miso = q.sh_out[30];
      end
      else if (!q.prev_cs && cs_n)
      begin
         next_q.done = 1'b1;
         next_q.rx = q.sh_in;
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.s1 <= RST_SPI_PINS;
         q.s2 <= RST_SPI_PINS;
         q.prev_cs <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end
   assign spi_miso = q.miso;
   assign fr.rx_word = q.rx;
   assign fr.frame_done = q.done;
endmodule
`default_nettype wire

/* design/oic_gate_code.sv */
`timescale 1ns/1ps
`default_nettype none
module oic_gate_code
   import oic_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] drv,
   input wire logic p_type,
   output logic pu_out,
   output logic pd_out
);
   typedef struct packed {
      logic pu;
      logic pd;
   } oic_gate_state_t;
   oic_gate_state_t q;
   oic_gate_state_t next_q;
   always_comb
   begin
      next_q = '0;
      case (drv)
         DRV_ON: next_q = p_type ? 2'b01 : 2'b10;
         DRV_OFF: next_q = p_type ? 2'b10 : 2'b01;
         DRV_TRI: next_q = 2'b00;
         default: next_q = 2'b00;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end
   assign pu_out = q.pu;
   assign pd_out = q.pd;
   pmos_on_a: assert property (@(posedge clk) disable iff (!rst_n)
      (drv == DRV_ON && p_type) |=> (pd_out && !pu_out))
      else $error("pmos on code wrong");
   nmos_on_a: assert property (@(posedge clk) disable iff (!rst_n)
      (drv == DRV_ON && !p_type) |=> (pu_out && !pd_out))
      else $error("nmos on code wrong");
endmodule
`default_nettype wire

/* design/oic_core.sv */
`timescale 1ns/1ps
`default_nettype none
module oic_core
   import oic_pkg::*;
#(
   parameter logic [10:0] ON_CYC = 11'(PULSE_ON_CYC),
   parameter logic [10:0] OFF_CYC = 11'(PULSE_OFF_CYC)
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic disable_in_pos,
   input wire logic disable_in_neg,
   input wire logic channel6_enable_pin,
   input wire logic device_reset_low,
   input wire logic [7:0] channel_input_pin_n,
   input wire logic logic_supply_ov,
   input wire logic logic_supply_uv,
   input wire logic logic_self_test_run,
   input wire logic logic_self_test_fail,
   input wire logic supply_monitor_self_check_run,
   input wire logic supply_monitor_self_check_fail,
   input wire logic battery_supply_uv,
   input wire logic charge_pump_uv,
   input wire logic comm_check_watchdog_expired,
   input wire logic [7:0] overcurrent_fault,
   input wire logic [7:0] short_to_ground_fault,
   input wire logic [7:0] short_to_battery_fault,
   input wire logic [7:0] open_load_fault,
   input wire logic [7:0] vout_above_high,
   input wire logic [7:0] vout_above_low,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic [7:0] gate_pullup_source,
   output logic [7:0] gate_pulldown_source
);
   typedef struct packed {
      logic [11:0] s1;
      logic [11:0] s2;
      logic [7:0] out_en;
      logic [7:0] prot_off;
      logic [7:0] drive;
      logic [7:0] insel;
      logic hbridge;
      logic [7:0] p_chan;
      logic [7:0] low_side;
      logic [7:0] p_on;
      logic [7:0] p_off;
      logic [7:0][10:0] pcnt;
      logic [NLATCH-1:0] latch;
      logic [7:0] oc_latch;
      logic [7:0][1:0] drv;
      logic [31:0] rdata;
      logic [31:0] reply;
   } oic_core_state_t;

   oic_core_state_t q;
   oic_core_state_t next_q;
   oic_frame_if fr ();

   logic disable_act;
   logic ch6_low;
   logic pinrst_act;
   logic [7:0] in_n;
   logic [7:0] grp;
   logic [7:0] cmd;
   logic [7:0] vflag;
   logic [7:0] off_req;
   logic [7:0] tri_req;
   logic [NLATCH-1:0] lclr;
   logic [NLATCH-1:0] lset;
   logic [7:0][2:0] gsrc;
   logic wr_pulse;
   logic selftest_fail;

   function automatic logic [31:0] mk_reply(input logic hi, input logic [3:0] v,
                                            input logic [3:0] c, input logic [11:0] g);
      logic [31:0] w;
      w = {hi ? HDR_HIGH : HDR_LOW, HDR_MID, v, c, g, 1'b0};
      w[0] = ^w[31:1];
      return w;
   endfunction

   oic_spi_frame u_spi (
      .clk(clk),
      .rst_n(rst_n),
      .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi),
      .spi_miso(spi_miso),
      .fr(fr.link)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_ch
         oic_gate_code u_gate (
            .clk(clk),
            .rst_n(rst_n),
            .drv(next_q.drv[gi]),
            .p_type(q.p_chan[gi]),
            .pu_out(gate_pullup_source[gi]),
            .pd_out(gate_pulldown_source[gi])
         );
         // feedback of the actual source state
         assign gsrc[gi] = q.p_chan[gi] ?
            {gate_pulldown_source[gi], gate_pullup_source[gi], 1'b0} :
            {1'b0, gate_pulldown_source[gi], gate_pullup_source[gi]};
      end
   endgenerate

   always_comb
   begin
      next_q = q;
      next_q.s1 = {channel_input_pin_n, device_reset_low, channel6_enable_pin,
                   disable_in_neg, disable_in_pos};
      next_q.s2 = q.s1;
      disable_act = q.s2[0] | ~q.s2[1];
      ch6_low = ~q.s2[2];
      pinrst_act = ~q.s2[3];
      in_n = q.s2[11:4];
      grp = q.hbridge ? MASK_ALL : MASK_MAIN;
      selftest_fail = 1'b0;

      // manual latches: set wins over clear
      lclr = (wr && addr == A_LATCH) ? wdata[NLATCH-1:0] : '0;
      lset = '0;
      lset[L_OVV] = logic_supply_ov;
      lset[L_SELFTEST] = logic_self_test_fail;
      lset[L_SELFCHK] = supply_monitor_self_check_fail;
      lset[L_PINRST] = pinrst_act;
      lset[L_WDG] = comm_check_watchdog_expired;
      next_q.latch = (q.latch & ~lclr) | lset;
      next_q.oc_latch = (wr && addr == A_LATCH) ?
         ((q.oc_latch & ~wdata[15:8]) | overcurrent_fault) :
         (q.oc_latch | overcurrent_fault);
      selftest_fail = next_q.latch[L_SELFTEST];

      // configuration writes
      if (wr)
      begin
         unique case (addr)
            A_OUT_EN: next_q.out_en = wdata[7:0];
            A_PROT_OFF: next_q.prot_off = wdata[7:0];
            A_DRIVE: next_q.drive = wdata[7:0];
            A_INSEL: next_q.insel = wdata[7:0];
            A_CONFIG:
            begin
               next_q.hbridge = wdata[0];
               next_q.p_chan = wdata[15:8];
               next_q.low_side = wdata[23:16];
            end
            default: ;
         endcase
      end
      wr_pulse = wr && addr == A_PULSE && !q.hbridge;

      cmd = (q.insel & q.drive) | (~q.insel & ~in_n);
      vflag = (q.low_side & vout_above_low) | (~q.low_side & vout_above_high);

      off_req = (grp & {8{disable_act | logic_supply_uv | next_q.latch[L_OVV]}})
              | (grp & {8{next_q.latch[L_WDG]}})
              | (grp & {8{selftest_fail}})
              | (grp & {8{supply_monitor_self_check_run | next_q.latch[L_SELFCHK]}})
              | {8{battery_supply_uv | charge_pump_uv}}
              | {8{next_q.latch[L_PINRST]}} | next_q.oc_latch
              | (MASK_CH6 & {8{ch6_low}})
              | q.prot_off;
      tri_req = (~grp & {8{selftest_fail | supply_monitor_self_check_run
                           | next_q.latch[L_SELFCHK]}})
              | ~q.out_en;

      for (int i = 0; i < 8; i++)
      begin
         // diagnostic pulses
         if (q.p_on[i] || q.p_off[i])
         begin
            if (q.pcnt[i] == '0)
            begin
               next_q.p_on[i] = 1'b0;
               next_q.p_off[i] = 1'b0;
            end
            else
            begin
               next_q.pcnt[i] = q.pcnt[i] - 11'h001;
            end
         end
         else if (wr_pulse && (wdata[i] || wdata[8 + i]))
         begin
            if (wdata[i] && (!wdata[8 + i] || q.drv[i] != DRV_ON))
            begin
               next_q.p_on[i] = 1'b1;
               next_q.pcnt[i] = ON_CYC - 11'h001;
            end
            else
            begin
               next_q.p_off[i] = 1'b1;
               next_q.pcnt[i] = OFF_CYC - 11'h001;
            end
         end
         if (q.hbridge)
         begin
            next_q.p_on[i] = 1'b0;
            next_q.p_off[i] = 1'b0;
         end
         // drive resolution
         if (logic_self_test_run)
            next_q.drv[i] = DRV_TRI;
         else if (off_req[i])
            next_q.drv[i] = DRV_OFF;
         else if (tri_req[i])
            next_q.drv[i] = DRV_TRI;
         else if (q.p_on[i])
            next_q.drv[i] = DRV_ON;
         else if (q.p_off[i])
            next_q.drv[i] = DRV_OFF;
         else
            next_q.drv[i] = cmd[i] ? DRV_ON : DRV_OFF;
      end

      // register reads, short and open-load faults only reported here
      next_q.rdata = '0;
      if (rd)
      begin
         unique case (addr)
            A_OUT_EN: next_q.rdata = {24'h00_0000, q.out_en};
            A_PROT_OFF: next_q.rdata = {24'h00_0000, q.prot_off};
            A_DRIVE: next_q.rdata = {24'h00_0000, q.drive};
            A_INSEL: next_q.rdata = {24'h00_0000, q.insel};
            A_CONFIG: next_q.rdata = {8'h00, q.low_side, q.p_chan, 7'h00, q.hbridge};
            A_PULSE: next_q.rdata = {16'h0000, q.p_off, q.p_on};
            A_LATCH: next_q.rdata = {16'h0000, q.oc_latch, 3'h0, q.latch};
            A_STATE: next_q.rdata = {cmd, vflag, q.drv};
            A_FAULT: next_q.rdata = {8'h00, open_load_fault,
                                     short_to_battery_fault, short_to_ground_fault};
            default: next_q.rdata = '0;
         endcase
      end

      // integrity queries
      if (fr.frame_done)
      begin
         if (fr.rx_word == CMD_LOW)
            next_q.reply = mk_reply(1'b0, vflag[3:0], cmd[3:0], gsrc[3:0]);
         else if (fr.rx_word == CMD_HIGH)
            next_q.reply = mk_reply(1'b1, vflag[7:4], cmd[7:4], gsrc[7:4]);
         else
            next_q.reply = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.s1 <= RST_PINS;
         q.s2 <= RST_PINS;
         q.out_en <= RST_OUT_EN;
         q.drv <= {8{DRV_TRI}};
      end
      else
      begin
         q <= next_q;
      end
   end

   assign rdata = q.rdata;
   assign fr.tx_word = q.reply;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   selftest_tri_a: assert property (logic_self_test_run |=> q.drv == 16'hAAAA)
      else $error("self test must three-state all");
   battery_off_a: assert property
      ((battery_supply_uv && !logic_self_test_run) |=> q.drv == 16'h0000)
      else $error("battery undervoltage must turn all off");
   ch6_pin_a: assert property
      ((!q.s2[2] && !logic_self_test_run) |=> q.drv[5] == DRV_OFF)
      else $error("channel 6 pin low must turn it off");
   prot_off_a: assert property
      ((q.prot_off[0] && !logic_self_test_run) |=> q.drv[0] == DRV_OFF)
      else $error("protect disable must turn channel off");
   pinrst_off_a: assert property
      ((q.latch[L_PINRST] && !(wr && addr == A_LATCH) && !logic_self_test_run)
       |=> q.drv == 16'h0000)
      else $error("reset latch must keep all off");
   ovv_hold_a: assert property
      ((q.latch[L_OVV] && !(wr && addr == A_LATCH && wdata[L_OVV])) |=> q.latch[L_OVV])
      else $error("manual latch released without clear");
   reply_low_a: assert property
      ((fr.frame_done && fr.rx_word == CMD_LOW) |=> q.reply[31:21] == 11'h5D5)
      else $error("low reply header wrong");
   reply_parity_a: assert property
      ((fr.frame_done && (fr.rx_word == CMD_LOW || fr.rx_word == CMD_HIGH))
       |=> !(^q.reply))
      else $error("reply parity odd");
   pulse_load_a: assert property ($rose(q.p_on[0]) |-> q.pcnt[0] == ON_CYC - 11'h001)
      else $error("on pulse length wrong");
   pulse_end_a: assert property
      ((q.p_on[0] && q.pcnt[0] == 11'h000) |=> !q.p_on[0])
      else $error("on pulse did not end");

   low_query_c: cover property (fr.frame_done && fr.rx_word == CMD_LOW);
   on_pulse_c: cover property ($rose(q.p_on[0]));
   latch_set_c: cover property (q.latch != '0);
endmodule
`default_nettype wire

/* testbench/oic_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
module oic_spi_host (
   input wire logic clk,
   input wire logic spi_miso,
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_mosi
);
   localparam int HALF = 6;
   initial
   begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // one mode 0 frame, msb first; reply bits taken at each rising sck
   task automatic xfer(input logic [31:0] word, output logic [31:0] reply);
      repeat (HALF) @(posedge clk);
      spi_cs_n <= 1'b0;
      for (int i = 31; i >= 0; i--)
      begin
         spi_mosi <= word[i];
         repeat (HALF) @(posedge clk);
         spi_sck <= 1'b1;
         reply[i] = spi_miso;
         repeat (HALF) @(posedge clk);
         spi_sck <= 1'b0;
      end
      repeat (HALF) @(posedge clk);
      spi_cs_n <= 1'b1;
      // released data line must not keep the last bit
      spi_mosi <= ~word[0];
      repeat (HALF) @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* testbench/output_disable_and_integrity_check_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module output_disable_and_integrity_check_bench import oic_pkg::*;;
   logic clk, rst_n, wr, rd, sck, cs_n, mosi, miso;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d, lo, hi;
   logic dpos, dneg_n, ch6_en, rpin_n, lov, luv, tst_run, tst_fail;
   logic chk_run, chk_fail, buv, cpuv, wdg;
   logic [7:0] pin_n, ovc, gshort, bshort, oload, vhi, vlo, pu, pd;
   logic [7:0] ev_off [14];
   logic [7:0] ev_tri [14];
   logic [15:0] ev_latch [14];
   int n_errors = 0;
   int num_checks = 0;

   oic_core #(.ON_CYC(11'h008), .OFF_CYC(11'h00A)) uut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .disable_in_pos(dpos), .disable_in_neg(dneg_n), .channel6_enable_pin(ch6_en),
      .device_reset_low(rpin_n), .channel_input_pin_n(pin_n), .logic_supply_ov(lov),
      .logic_supply_uv(luv), .logic_self_test_run(tst_run), .logic_self_test_fail(tst_fail),
      .supply_monitor_self_check_run(chk_run), .supply_monitor_self_check_fail(chk_fail),
      .battery_supply_uv(buv), .charge_pump_uv(cpuv), .comm_check_watchdog_expired(wdg),
      .overcurrent_fault(ovc), .short_to_ground_fault(gshort),
      .short_to_battery_fault(bshort), .open_load_fault(oload), .vout_above_high(vhi),
      .vout_above_low(vlo), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso), .gate_pullup_source(pu), .gate_pulldown_source(pd));
   oic_spi_host u_host (.clk(clk), .spi_miso(miso), .spi_sck(sck), .spi_cs_n(cs_n),
      .spi_mosi(mosi));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      // taken before this edge's update, so the value of the answer cycle
      @(posedge clk);
      v = rdata;
   endtask

   function automatic logic [15:0] exp_state(input logic [7:0] off, input logic [7:0] tm);
      logic [15:0] s;
      for (int i = 0; i < 8; i++)
         s[2*i+:2] = off[i] ? 2'h0 : (tm[i] ? 2'h2 : 2'h1);
      return s;
   endfunction

   function automatic logic [31:0] mk_reply(input logic [3:0] h, input logic [3:0] v,
      input logic [3:0] c, input logic [11:0] g);
      logic [31:0] w;
      w = {h, 1'b1, 6'h15, v, c, g, 1'b0};
      w[0] = ^w;
      return w;
   endfunction

   // drive code and gate sources, all channels n-type
   task automatic chk_state(input logic [15:0] s);
      logic [31:0] v;
      logic [7:0] on_m, off_m;
      for (int i = 0; i < 8; i++)
      begin
         on_m[i] = s[2*i+:2] == 2'h1;
         off_m[i] = s[2*i+:2] == 2'h0;
      end
      rd_reg(A_STATE, v);
      cmp(32'(v[15:0]), 32'(s));
      cmp(32'(pu), 32'(on_m));
      cmp(32'(pd), 32'(off_m));
   endtask

   task automatic set_ev(input int k, input logic v);
      case (k)
         0: dpos <= v;
         1: dneg_n <= ~v;
         2: luv <= v;
         3: buv <= v;
         4: cpuv <= v;
         5: ch6_en <= ~v;
         6: tst_run <= v;
         7: chk_run <= v;
         8: lov <= v;
         9: tst_fail <= v;
         10: chk_fail <= v;
         11: rpin_n <= ~v;
         12: wdg <= v;
         default: ovc <= {v, 7'h00};
      endcase
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      n_errors++;
      stop_test();
   end

   initial
   begin
      ev_off = '{8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'h20, 8'h00, 8'h3F, 8'h3F, 8'h3F,
         8'h3F, 8'hFF, 8'h3F, 8'h80};
      ev_tri = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hC0, 8'h00, 8'hC0,
         8'hC0, 8'h00, 8'h00, 8'h00};
      ev_latch = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
         16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h8000};
      {rst_n, wr, rd, dpos, lov, luv, tst_run, tst_fail, chk_run, chk_fail} = '0;
      {buv, cpuv, wdg, ovc, gshort, bshort, oload, vhi, vlo} = '0;
      {dneg_n, ch6_en, rpin_n} = 3'h7;
      pin_n = 8'hFF;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      chk_state(16'hAAAA);
      wr_reg(8'h44, 32'h0000_00FF);
      rd_reg(8'h40, d);
      cmp(d, 32'h0000_0000);
      rd_reg(A_OUT_EN, d);
      cmp(d, 32'h0000_0000);
      wr_reg(A_OUT_EN, 32'h0000_00FF);
      wr_reg(A_DRIVE, 32'h0000_000F);
      wr_reg(A_INSEL, 32'h0000_00FF);
      rd_reg(A_STATE, d);
      cmp(32'(d[31:24]), 32'h0000_000F);
      chk_state(exp_state(8'hF0, 8'h00));
      wr_reg(A_OUT_EN, 32'h0000_00FE);
      chk_state(exp_state(8'hF0, 8'h01));
      wr_reg(A_OUT_EN, 32'h0000_00FF);
      wr_reg(A_DRIVE, 32'h0000_00FF);
      chk_state(16'h5555);
      for (int k = 0; k < 14; k++)
      begin
         set_ev(k, 1'b1);
         cyc(5);
         if (k > 7)
         begin
            set_ev(k, 1'b0);
            cyc(5);
         end
         chk_state(exp_state(ev_off[k], ev_tri[k]));
         rd_reg(A_LATCH, d);
         cmp(d, 32'(ev_latch[k]));
         set_ev(k, 1'b0);
         wr_reg(A_LATCH, 32'(ev_latch[k]));
         cyc(3);
         chk_state(16'h5555);
      end
      wr_reg(A_PROT_OFF, 32'h0000_0081);
      chk_state(exp_state(8'h81, 8'h00));
      wr_reg(A_PROT_OFF, 32'h0000_0000);
      chk_state(16'h5555);
      gshort <= 8'h01;
      bshort <= 8'h02;
      oload <= 8'h04;
      cyc(2);
      rd_reg(A_FAULT, d);
      cmp(d, 32'h0004_0201);
      chk_state(16'h5555);
      wr_reg(A_CONFIG, 32'h0000_0001);
      set_ev(0, 1'b1);
      cyc(5);
      chk_state(exp_state(8'hFF, 8'h00));
      set_ev(0, 1'b0);
      wr_reg(A_CONFIG, 32'h0000_0000);
      cyc(5);
      wr_reg(A_DRIVE, 32'h0000_00FE);
      wr_reg(A_PULSE, 32'h0000_0001);
      rd_reg(A_PULSE, d);
      cmp(d, 32'h0000_0001);
      chk_state(16'h5555);
      cyc(12);
      chk_state(16'h5554);
      wr_reg(A_PULSE, 32'h0000_0200);
      chk_state(16'h5550);
      cyc(14);
      chk_state(16'h5554);
      wr_reg(A_PULSE, 32'h0000_0101);
      chk_state(16'h5555);
      cyc(14);
      wr_reg(A_OUT_EN, 32'h0000_00F7);
      wr_reg(A_DRIVE, 32'h0000_005A);
      wr_reg(A_INSEL, 32'h0000_00FE);
      wr_reg(A_CONFIG, 32'h0004_0200);
      pin_n <= 8'hFE;
      vhi <= 8'h31;
      vlo <= 8'h0C;
      cyc(4);
      cmp(32'(pu), 32'h0000_0051);
      cmp(32'(pd), 32'h0000_00A6);
      rd_reg(A_STATE, d);
      cmp(32'(d[31:16]), 32'h0000_5B35);
      lo = mk_reply(4'hB, 4'h5, 4'hB, 12'h0A1);
      hi = mk_reply(4'hC, 4'h3, 4'h5, 12'h451);
      u_host.xfer(CMD_LOW, d);
      cmp(d, 32'h0000_0000);
      u_host.xfer(CMD_HIGH, d);
      cmp(d, lo);
      u_host.xfer(32'h1234_5678, d);
      cmp(d, hi);
      u_host.xfer(32'h0000_0000, d);
      cmp(d, 32'h0000_0000);
      stop_test();
   end
endmodule
`default_nettype wire
